// ### hw/processor_system_control.sv
// Processor system control: clocks, lock, speed, power-down, breakpoint, interrupts
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ns
module processor_system_control
    import sysctl_pkg::*;
#(
    parameter logic [7:0] VERSION_INT  = 8'h00,  // Arbitrary value
    parameter logic [7:0] VERSION_FRAC = 8'h01,  // Arbitrary value
    parameter int         DLY1_CYC     = DLY1_MS * CYC_PER_MS,
    parameter int         DLY2_CYC     = DLY2_MS * CYC_PER_MS,
    parameter int         DLY3_CYC     = DLY3_MS * CYC_PER_MS
) (
    // Clock and reset
    input  wire logic              sys_clk,
    input  wire logic              sys_rst,
    // Register port
    input  wire logic [ADDR_W-1:0] regAddr,
    input  wire logic [DATA_W-1:0] regWdata,
    input  wire logic              regWr,
    input  wire logic              regRd,
    output logic      [DATA_W-1:0] regRdata,
    // Processor bus observation
    input  wire logic              cpuAccess,
    input  wire logic [ADDR_W-1:0] cpuAddr,
    // Clock pins and clock selects
    input  wire logic              auxClockIn,
    output logic                   auxClockOut,
    output logic                   auxClockOe,
    output logic      [2:0]        procClockSel,
    output logic                   periphClockX4,
    output logic                   procClockEn,
    output logic      [1:0]        chipMode,
    // Interrupt sources, one-cycle pulses from this clock domain; the two external pins are levels passed through a synchroniser
    input  wire logic [IRQ_USED-1:0] irqSrc,
    input  wire logic              sofToken,
    input  wire logic              usbActivity,
    input  wire logic              external_irq_pin0,
    input  wire logic              external_irq_pin1,
    // Interrupt request to the processor
    output logic                   irqValid,
    output logic      [6:0]        irqNumber,
    input  wire logic              irqAck,
    // Power state
    output logic                   periphPause,
    output logic                   cpuStopped
);
    initial begin
        if (DLY1_CYC < 1 || DLY2_CYC < DLY1_CYC || DLY3_CYC < DLY2_CYC)
            $error("power-up delay counts out of order");
    end

    localparam int CNT_W = $clog2(DLY3_CYC + 1);

    logic [6:0]              cfg_ff;
    logic [3:0]              speed_ff;
    logic [POWER_MSB:0]      power_ff;
    logic [IRQ_EN_MSB:0]     irqEn_ff;
    logic [15:0]             break_ff;
    logic [3:0]              pinCtl_ff;
    logic [DATA_W-1:0]       vec_ff [VEC_COUNT];
    logic [DATA_W-1:0]       regRdata_ff;
    logic [IRQ_USED-1:0]     pend_ff;
    logic                    brkPend_ff;
    logic [1:0]              pin0Sync_ff, pin1Sync_ff, auxSync_ff;
    logic                    pin0Last_ff, pin1Last_ff;
    logic [3:0]              divCnt_ff;
    logic [CNT_W-1:0]        dlyCnt_ff;
    pwr_state_t              pwr_ff;

    logic                    wrCfg;
    logic [2:0]              clkSrc;
    logic                    pin0Edge, pin1Edge;
    logic [IRQ_USED-1:0]     events, gated;
    logic                    wake;
    logic [CNT_W-1:0]        dlyLoad;

    assign clkSrc   = cfg_ff[CLK_SRC_MSB:CLK_SRC_LSB];
    assign chipMode = cfg_ff[MODE_HI_BIT:MODE_LO_BIT];

    // Configuration register with its two sticky locks
    assign wrCfg = regWr && regAddr == OFS_CONFIG && !cfg_ff[CFG_LOCK_BIT];
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cfg_ff <= CONFIG_RESET[6:0];
        end else if (wrCfg) begin
            cfg_ff[CFG_LOCK_BIT] <= regWdata[CFG_LOCK_BIT];
            cfg_ff[MODE_HI_BIT:MODE_LO_BIT] <= regWdata[MODE_HI_BIT:MODE_LO_BIT];
            if (!cfg_ff[CLK_LOCK_BIT]) begin
                cfg_ff[CLK_LOCK_BIT] <= regWdata[CLK_LOCK_BIT];
                cfg_ff[CLK_SRC_MSB:CLK_SRC_LSB] <= regWdata[CLK_SRC_MSB:CLK_SRC_LSB];
            end
        end
    end

    // Clock selection: code passed to the clock generator
    assign procClockSel  = clkSrc;
    assign periphClockX4 = clkSrc[2];
    assign auxClockOe    = clkSrc[1] & (clkSrc[0] | clkSrc[2]);

    // Auxiliary pin synchronised every cycle; its level is used only when selected as processor clock source
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            auxSync_ff <= 2'h0;
        end else begin
            auxSync_ff <= {auxSync_ff[0], auxClockIn};
        end
    end

    // Speed divider: one enable pulse every speed+1 cycles
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            speed_ff <= SPEED_RESET;
        end else if (regWr && regAddr == OFS_SPEED) begin
            speed_ff <= regWdata[SPEED_MSB:0];
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            divCnt_ff <= 4'h0;
        end else if (divCnt_ff >= speed_ff) begin
            divCnt_ff <= 4'h0;
        end else begin
            divCnt_ff <= divCnt_ff + 4'h1;
        end
    end

    // Processor tick: divided system clock, gated by the aux pin level when code 010
    logic procTick;
    assign procTick = (clkSrc == CSRC_AUX) ? auxSync_ff[1] : 1'b1;
    assign procClockEn = (divCnt_ff == 4'h0) && procTick && pwr_ff == PWR_RUN;
    // Observation copy of processor clock
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            auxClockOut <= 1'b0;
        end else begin
            auxClockOut <= procClockEn;
        end
    end

    // Power-down register
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            power_ff <= '0;
        end else if (regWr && regAddr == OFS_POWER) begin
            power_ff <= regWdata[POWER_MSB:0];
        end else if (pwr_ff == PWR_DELAY && dlyCnt_ff == '0) begin
            power_ff[SUSPEND_BIT] <= 1'b0;
            power_ff[HALT_BIT]    <= 1'b0;
        end
    end

    // Other registers
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            irqEn_ff  <= '0;
            break_ff  <= 16'h0000;
            pinCtl_ff <= 4'h0;
        end else if (regWr) begin
            if (regAddr == OFS_IRQ_EN)  irqEn_ff  <= regWdata[IRQ_EN_MSB:0];
            if (regAddr == OFS_BREAK)   break_ff  <= regWdata;
            if (regAddr == OFS_PIN_IRQ) pinCtl_ff <= regWdata[3:0];
        end
    end

    // Vector memory at 0x0000..0x003E, word per vector
    always_ff @(posedge sys_clk) begin
        if (regWr && regAddr <= VEC_LAST && !regAddr[0]) begin
            vec_ff[regAddr[6:1]] <= regWdata;
        end
    end

    // External pin edge detection
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pin0Sync_ff <= 2'h0;
            pin1Sync_ff <= 2'h0;
            pin0Last_ff <= 1'b0;
            pin1Last_ff <= 1'b0;
        end else begin
            pin0Sync_ff <= {pin0Sync_ff[0], external_irq_pin0};
            pin1Sync_ff <= {pin1Sync_ff[0], external_irq_pin1};
            pin0Last_ff <= pin0Sync_ff[1];
            pin1Last_ff <= pin1Sync_ff[1];
        end
    end
    assign pin0Edge = (pin0Sync_ff[1] != pin0Last_ff)
                    && (pin0Sync_ff[1] == pinCtl_ff[PIN0_POL_BIT])
                    && pinCtl_ff[PIN0_EN_BIT] && irqEn_ff[EN_PIN];
    assign pin1Edge = (pin1Sync_ff[1] != pin1Last_ff)
                    && (pin1Sync_ff[1] == pinCtl_ff[PIN1_POL_BIT])
                    && pinCtl_ff[PIN1_EN_BIT] && irqEn_ff[EN_PIN];

    // Event map and group gating
    always_comb begin
        events = irqSrc;
        events[IRQ_PIN0] = pin0Edge;
        events[IRQ_PIN1] = pin1Edge;
        events[IRQ_SOF]  = irqSrc[IRQ_SOF] | sofToken;
        gated = '0;
        gated[IRQ_TIMER0] = events[IRQ_TIMER0] & irqEn_ff[EN_TIMER0];
        gated[IRQ_TIMER1] = events[IRQ_TIMER1] & irqEn_ff[EN_TIMER1];
        gated[IRQ_PIN0]   = events[IRQ_PIN0];
        gated[IRQ_PIN1]   = events[IRQ_PIN1];
        gated[IRQ_SER_TX] = events[IRQ_SER_TX] & irqEn_ff[EN_SERIAL];
        gated[IRQ_SER_RX] = events[IRQ_SER_RX] & irqEn_ff[EN_SERIAL];
        gated[IRQ_FAST]   = events[IRQ_FAST] & irqEn_ff[EN_FAST];
        for (int i = IRQ_USB_RESET; i < IRQ_MBX_TX; i++) begin
            gated[i] = events[i] & irqEn_ff[EN_USB];
        end
        gated[IRQ_MBX_TX] = events[IRQ_MBX_TX] & irqEn_ff[EN_MAILBOX];
        gated[IRQ_MBX_RX] = events[IRQ_MBX_RX] & irqEn_ff[EN_MAILBOX];
    end

    // Pending flags; new event wins over acknowledge
    logic [4:0] ackNum;
    assign ackNum = irqNumber[4:0];
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pend_ff <= '0;
        end else begin
            for (int i = 0; i < IRQ_USED; i++) begin
                if (gated[i])
                    pend_ff[i] <= 1'b1;
                else if (irqAck && irqValid && !brkPend_ff && ackNum == 5'(i))
                    pend_ff[i] <= 1'b0;
            end
        end
    end

    // Breakpoint compare
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            brkPend_ff <= 1'b0;
        end else if (cpuAccess && cpuAddr == break_ff) begin
            brkPend_ff <= 1'b1;
        end else if (irqAck) begin
            brkPend_ff <= 1'b0;
        end
    end

    // Lowest-number pending interrupt, breakpoint first
    always_comb begin
        irqNumber = 7'h00;
        for (int i = IRQ_USED - 1; i >= 0; i--) begin
            if (pend_ff[i]) irqNumber = 7'(i);
        end
        if (brkPend_ff) irqNumber = BREAK_VECTOR;
    end
    assign irqValid = brkPend_ff || (|pend_ff);

    // Power state machine
    assign wake = (|gated) || brkPend_ff
                || (power_ff[WAKE_USB_BIT] && usbActivity)
                || (power_ff[WAKE_PIN_BIT] && (pin0Sync_ff[1] != pin0Last_ff
                                              || pin1Sync_ff[1] != pin1Last_ff));
    always_comb begin
        unique case (power_ff[PUD_MSB:PUD_LSB])
            2'h0: dlyLoad = '0;
            2'h1: dlyLoad = CNT_W'(DLY1_CYC);
            2'h2: dlyLoad = CNT_W'(DLY2_CYC);
            2'h3: dlyLoad = CNT_W'(DLY3_CYC);
        endcase
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pwr_ff    <= PWR_RUN;
            dlyCnt_ff <= '0;
        end else begin
            unique case (pwr_ff)
                PWR_RUN: begin
                    if (power_ff[SUSPEND_BIT]) pwr_ff <= PWR_SUSP;
                    else if (power_ff[HALT_BIT]) pwr_ff <= PWR_HALT;
                end
                PWR_HALT: begin
                    if (irqValid) begin
                        pwr_ff    <= PWR_DELAY;
                        dlyCnt_ff <= '0;
                    end
                end
                PWR_SUSP: begin
                    if (wake) begin
                        pwr_ff    <= PWR_DELAY;
                        dlyCnt_ff <= dlyLoad;
                    end
                end
                PWR_DELAY: begin
                    if (dlyCnt_ff == '0) pwr_ff <= PWR_RUN;
                    else dlyCnt_ff <= dlyCnt_ff - CNT_W'(1);
                end
            endcase
        end
    end
    assign periphPause = pwr_ff == PWR_SUSP;
    assign cpuStopped  = pwr_ff != PWR_RUN;

    // Read port
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            regRdata_ff <= '0;
        end else if (regRd) begin
            regRdata_ff <= '0;
            if (regAddr <= VEC_LAST && !regAddr[0])
                regRdata_ff <= vec_ff[regAddr[6:1]];
            unique case (regAddr)
                OFS_VERSION:  regRdata_ff <= {VERSION_INT, VERSION_FRAC};
                OFS_CONFIG:   regRdata_ff <= {9'h000, cfg_ff};
                OFS_SPEED:    regRdata_ff <= {12'h000, speed_ff};
                OFS_POWER:    regRdata_ff <= {10'h000, power_ff};
                OFS_IRQ_EN:   regRdata_ff <= {9'h000, irqEn_ff};
                OFS_BREAK:    regRdata_ff <= break_ff;
                OFS_PIN_IRQ:  regRdata_ff <= {12'h000, pinCtl_ff};
                OFS_IRQ_STAT: regRdata_ff <= {13'h0000, pend_ff[IRQ_USED-1:16]};
                default: ;
            endcase
        end
    end
    assign regRdata = regRdata_ff;

    // Checks
    AST_CLK_LOCK: assert property (@(posedge sys_clk) disable iff (sys_rst)
        $past(cfg_ff[CLK_LOCK_BIT]) |-> cfg_ff[CLK_LOCK_BIT] && $stable(clkSrc))
        else $error("clock configuration changed while locked");
    AST_CFG_LOCK: assert property (@(posedge sys_clk) disable iff (sys_rst)
        $past(cfg_ff[CFG_LOCK_BIT]) |-> $stable(cfg_ff))
        else $error("configuration changed while locked");
    AST_OE: assert property (@(posedge sys_clk) disable iff (sys_rst)
        auxClockOe == (clkSrc == 3'h3 || clkSrc == 3'h6 || clkSrc == 3'h7))
        else $error("clock output enable wrong");
    AST_DIV: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (divCnt_ff == 4'h0 && speed_ff == 4'h1 && $stable(speed_ff)) |=> divCnt_ff == 4'h1
        ##1 divCnt_ff == 4'h0)
        else $error("divider period wrong");
    AST_BRK: assert property (@(posedge sys_clk) disable iff (sys_rst)
        cpuAccess && cpuAddr == break_ff |=> irqValid && irqNumber == BREAK_VECTOR)
        else $error("breakpoint not raised");
    AST_SOF: assert property (@(posedge sys_clk) disable iff (sys_rst)
        sofToken && irqEn_ff[EN_USB] |=> pend_ff[IRQ_SOF])
        else $error("frame interrupt missing");
    AST_GATE: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !irqEn_ff[EN_TIMER0] && !pend_ff[IRQ_TIMER0] && !(regWr && regAddr == OFS_IRQ_EN)
        |=> !pend_ff[IRQ_TIMER0])
        else $error("disabled timer interrupt pending");
    AST_PAUSE: assert property (@(posedge sys_clk) disable iff (sys_rst)
        pwr_ff == PWR_SUSP |-> periphPause && !procClockEn)
        else $error("peripherals run in power-down");
    AST_DELAY: assert property (@(posedge sys_clk) disable iff (sys_rst)
        pwr_ff == PWR_SUSP && wake && power_ff[PUD_MSB:PUD_LSB] == 2'h0 |=> ##1 pwr_ff == PWR_RUN)
        else $error("zero delay wake too slow");
endmodule

// ### hw/sysctl_pkg.sv
// Constants, register map and field layout of the processor system-control block
package sysctl_pkg;
    localparam int          DATA_W         = 16;
    localparam int          ADDR_W         = 16;
    // Register offsets
    localparam logic [15:0] OFS_VERSION    = 16'hC004;
    localparam logic [15:0] OFS_CONFIG     = 16'hC006;
    localparam logic [15:0] OFS_SPEED      = 16'hC008;
    localparam logic [15:0] OFS_POWER      = 16'hC00A;
    localparam logic [15:0] OFS_IRQ_EN     = 16'hC00E;
    localparam logic [15:0] OFS_BREAK      = 16'hC014;
    localparam logic [15:0] OFS_PIN_IRQ    = 16'hC01C;
    localparam logic [15:0] OFS_IRQ_STAT   = 16'hC020;
    // Vector area: 32 words from 0x0000 to 0x003E
    localparam logic [15:0] VEC_BASE       = 16'h0000;
    localparam logic [15:0] VEC_LAST       = 16'h003E;
    localparam int          VEC_COUNT      = 64;
    localparam logic [6:0]  BREAK_VECTOR   = 7'h7F;
    // Configuration fields
    localparam int          CFG_LOCK_BIT   = 0;
    localparam int          MODE_LO_BIT    = 1;
    localparam int          MODE_HI_BIT    = 2;
    localparam int          CLK_LOCK_BIT   = 3;
    localparam int          CLK_SRC_LSB    = 4;
    localparam int          CLK_SRC_MSB    = 6;
    localparam int          SPEED_MSB      = 3;
    // Power-down fields
    localparam int          HALT_BIT       = 0;
    localparam int          SUSPEND_BIT    = 1;
    localparam int          PUD_LSB        = 2;
    localparam int          PUD_MSB        = 3;
    localparam int          WAKE_PIN_BIT   = 4;
    localparam int          WAKE_USB_BIT   = 5;
    localparam int          POWER_MSB      = 5;
    // Interrupt group enable bits
    localparam int          EN_TIMER0      = 0;
    localparam int          EN_TIMER1      = 1;
    localparam int          EN_PIN         = 2;
    localparam int          EN_SERIAL      = 3;
    localparam int          EN_FAST        = 4;
    localparam int          EN_USB         = 5;
    localparam int          EN_MAILBOX     = 6;
    localparam int          IRQ_EN_MSB     = 6;
    // Pin interrupt control bits
    localparam int          PIN0_EN_BIT    = 0;
    localparam int          PIN0_POL_BIT   = 1;
    localparam int          PIN1_EN_BIT    = 2;
    localparam int          PIN1_POL_BIT   = 3;
    // Hardware interrupt numbers
    localparam int          IRQ_TIMER0     = 0;
    localparam int          IRQ_TIMER1     = 1;
    localparam int          IRQ_PIN0       = 2;
    localparam int          IRQ_PIN1       = 3;
    localparam int          IRQ_SER_TX     = 4;
    localparam int          IRQ_SER_RX     = 5;
    localparam int          IRQ_FAST       = 6;
    localparam int          IRQ_USB_RESET  = 7;
    localparam int          IRQ_SOF        = 8;
    localparam int          IRQ_EP_BASE    = 9;
    localparam int          IRQ_MBX_TX     = 17;
    localparam int          IRQ_MBX_RX     = 18;
    localparam int          IRQ_USED       = 19;
    // Reset values
    localparam logic [3:0]  SPEED_RESET    = 4'hF;
    localparam logic [15:0] CONFIG_RESET   = 16'h0000;
    // Chip mode codes
    localparam logic [1:0]  MODE_PINS      = 2'h0;
    localparam logic [1:0]  MODE_FULL      = 2'h3;
    // Clock source codes
    localparam logic [2:0]  CSRC_AUX       = 3'h2;
    // Power-up delay in ms per code and the system clock
    localparam int          CLK_HZ         = 20_000_000;
    localparam int          DLY1_MS        = 1;
    localparam int          DLY2_MS        = 8;
    localparam int          DLY3_MS        = 64;
    localparam int          CYC_PER_MS     = CLK_HZ / 1000;

    typedef enum logic [1:0] {
        PWR_RUN   = 2'b00,
        PWR_HALT  = 2'b01,
        PWR_SUSP  = 2'b10,
        PWR_DELAY = 2'b11
    } pwr_state_t;
endpackage

// ### testbench/processor_system_control_tb.sv
// Self-checking bench for the processor system-control block
`timescale 1ns/1ns
module processor_system_control_tb;
    import sysctl_pkg::*;
    logic                sys_clk = 0, sys_rst = 1, regWr = 0, regRd = 0, rdD = 0;
    logic                cpuAccess = 0, sofToken = 0, usbActivity = 0, irqAck = 0;
    logic [15:0]         regAddr = 0, regWdata = 0, cpuAddr = 0, regRdata, v;
    logic [IRQ_USED-1:0] irqSrc = '0;
    logic                auxIn = 0, pin0 = 0, pin1 = 0;
    int                  t;
    logic                auxClockOut, auxClockOe, periphClockX4, procClockEn;
    logic                irqValid, periphPause, cpuStopped;
    logic [2:0]          procClockSel;
    logic [1:0]          chipMode;
    logic [6:0]          irqNumber;
    logic [31:0]         seed = 32'h4F61;
    logic [15:0]         q[$];
    int                  error_cnt = 0, checks = 0, n, i;

    processor_system_control #(.VERSION_INT(8'h12), .VERSION_FRAC(8'h34),
        .DLY1_CYC(4), .DLY2_CYC(8), .DLY3_CYC(16)) DUT (
        .sys_clk, .sys_rst, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
        .cpuAccess, .cpuAddr, .auxClockIn(auxIn), .auxClockOut, .auxClockOe,
        .procClockSel, .periphClockX4, .procClockEn, .chipMode, .irqSrc, .sofToken,
        .usbActivity, .external_irq_pin0(pin0), .external_irq_pin1(pin1),
        .irqValid, .irqNumber, .irqAck, .periphPause, .cpuStopped);

    always #25 sys_clk = ~sys_clk;

    function logic [15:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[15:0];
    endfunction

    task chk(input string nm, input logic [15:0] s, input logic [15:0] e);
        checks++;
        if (s !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask

    task results();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task tmo();
        error_cnt++;
        $display("ERROR wait bound used up");
        results();
    endtask

    // Counts processor ticks and their pin copy over c cycles
    task ticks(input int c, output int te, output int to);
        te = 0;
        to = 0;
        repeat (c) begin
            @(negedge sys_clk);
            if (procClockEn === 1'b1) te++;
            if (auxClockOut === 1'b1) to++;
        end
    endtask

    task wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        regAddr  <= a;
        regWdata <= d;
        regWr    <= 1'b1;
        @(posedge sys_clk);
        regWr    <= 1'b0;
    endtask

    // Expected read data queued for the monitor
    task rd(input logic [15:0] a, input logic [15:0] e);
        @(posedge sys_clk);
        regAddr <= a;
        regRd   <= 1'b1;
        q.push_back(e);
        @(posedge sys_clk);
        regRd   <= 1'b0;
    endtask

    // Event: 0..18 irqSrc bit, 19 frame token, 20 access, 21/22 pin0/pin1 toggle
    task ev(input int k, input logic vld, input logic [6:0] num);
        @(posedge sys_clk);
        if (k < 19) irqSrc[k] <= 1'b1;
        else if (k == 19) sofToken <= 1'b1;
        else if (k == 20) cpuAccess <= 1'b1;
        else if (k == 21) pin0 <= ~pin0;
        else pin1 <= ~pin1;
        @(posedge sys_clk);
        irqSrc    <= '0;
        sofToken  <= 1'b0;
        cpuAccess <= 1'b0;
        // Pin edges pass the two-stage synchroniser first
        if (k > 20) repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        chk("irqValid", 16'(irqValid), 16'(vld));
        if (vld) begin
            chk("irqNumber", 16'(irqNumber), 16'(num));
            @(posedge sys_clk);
            irqAck <= 1'b1;
            @(posedge sys_clk);
            irqAck <= 1'b0;
        end
    endtask

    always @(posedge sys_clk) begin
        if (rdD) chk("regRdata", regRdata, q.pop_front());
        rdD <= regRd;
    end

    initial begin
        repeat (5) @(posedge sys_clk);
        sys_rst <= 1'b0;
        rd(OFS_SPEED, 16'h000F);
        rd(OFS_CONFIG, CONFIG_RESET);
        rd(OFS_VERSION, 16'h1234);
        rd(16'hC002, 16'h0000);
        v = rnd();
        wr(VEC_LAST, v);
        rd(VEC_LAST, v);
        for (i = 0; i < 8; i++) begin
            wr(OFS_CONFIG, 16'(i * 16 + 6));
            @(negedge sys_clk);
            chk("procClockSel", 16'(procClockSel), 16'(i));
            chk("periphClockX4", 16'(periphClockX4), 16'(i / 4));
            chk("auxClockOe", 16'(auxClockOe), 16'(i == 3 || i > 5));
            chk("chipMode", 16'(chipMode), 16'(MODE_FULL));
            if (i == 0 || i == 2) begin
                ticks(16, n, t);
                chk("procClockEn", 16'(n), 16'(i == 0));
                if (i == 0) chk("auxClockOut", 16'(t), 16'h0001);
            end
            if (i == 2) begin
                @(posedge sys_clk);
                auxIn <= 1'b1;
                repeat (3) @(posedge sys_clk);
                ticks(16, n, t);
                chk("procClockEn", 16'(n), 16'h0001);
                chk("auxClockOut", 16'(t), 16'h0001);
                @(posedge sys_clk);
                auxIn <= 1'b0;
            end
        end
        wr(OFS_CONFIG, 16'h0058);
        @(negedge sys_clk);
        chk("chipMode", 16'(chipMode), 16'(MODE_PINS));
        wr(OFS_CONFIG, 16'h0026);
        rd(OFS_CONFIG, 16'h005E);
        wr(OFS_CONFIG, 16'h0001);
        wr(OFS_CONFIG, 16'h0006);
        rd(OFS_CONFIG, 16'h0059);
        v = rnd() & 16'h000F;
        wr(OFS_SPEED, v);
        rd(OFS_SPEED, v);
        for (n = 0; n < 40 && procClockEn !== 1'b1; n++) @(negedge sys_clk);
        if (n >= 40) tmo();
        n = 0;
        do begin
            @(negedge sys_clk);
            n++;
        end while (procClockEn !== 1'b1 && n < 40);
        if (n >= 40) tmo();
        chk("tick period", 16'(n), v + 16'h0001);
        wr(OFS_IRQ_EN, 16'h0021);
        ev(1, 1'b0, 7'h00);
        ev(0, 1'b1, 7'h00);
        ev(19, 1'b1, 7'h08);
        wr(OFS_PIN_IRQ, 16'h0007);
        ev(21, 1'b0, 7'h00);
        ev(21, 1'b0, 7'h00);
        wr(OFS_IRQ_EN, 16'h0025);
        ev(21, 1'b1, 7'h02);
        ev(21, 1'b0, 7'h00);
        ev(22, 1'b0, 7'h00);
        ev(22, 1'b1, 7'h03);
        v = rnd();
        wr(OFS_BREAK, v);
        cpuAddr <= v;
        ev(20, 1'b1, BREAK_VECTOR);
        wr(OFS_POWER, 16'h0001);
        repeat (2) @(negedge sys_clk);
        chk("cpuStopped", 16'(cpuStopped), 16'h0001);
        ev(0, 1'b1, 7'h00);
        @(negedge sys_clk);
        chk("cpuStopped", 16'(cpuStopped), 16'h0000);
        wr(OFS_POWER, 16'h0026);
        repeat (2) @(negedge sys_clk);
        chk("cpuStopped", 16'(cpuStopped), 16'h0001);
        chk("periphPause", 16'(periphPause), 16'h0001);
        @(posedge sys_clk);
        usbActivity <= 1'b1;
        @(posedge sys_clk);
        usbActivity <= 1'b0;
        n = 0;
        while (cpuStopped !== 1'b0 && n < 50) begin
            @(negedge sys_clk);
            n++;
        end
        if (n >= 50) tmo();
        chk("wake delay", 16'(n >= 4 && n <= 8), 16'h0001);
        chk("periphPause", 16'(periphPause), 16'h0000);
        repeat (3) @(posedge sys_clk);
        results();
    end
endmodule
